// ==== src/spms_port.sv ====
// Full-duplex serial port, master or slave role, with an Avalon-MM register slave.
//
// Contract
// [RULE_01] Works as master or slave; master shift clock reaches half the system clock.
// [RULE_02] Transmit byte waits in a write buffer while the current byte shifts.
// [RULE_03] Each received byte moves to a read buffer, freeing the shifter at once.
// [RULE_04] Master drives MOSI, slave reads it; eight bits from master to slave.
// [RULE_05] MISO carries slave data; master samples it, selected slave drives it.
// [RULE_06] Shift clock pin is an output as master and an input as slave.
// [RULE_07] Master produces exactly eight shift clock periods per byte exchanged.
// [RULE_08] Select stays low through an access; a deselected slave goes inactive.
// [RULE_09] Only one master on the bus at any time.
// [RULE_10] Master selects only one slave at any time.
// [RULE_11] As master, the select pin may be set up as a mode-fault input.
// [RULE_12] Master and slave shifters form one sixteen-bit ring; contents swap.
// [RULE_13] MSB first by default, LSB first when selected; data bit weights unchanged.
// [RULE_14] Select output enable: 0 gives plain I/O, 1 gives automatic per-byte select; code drives select only as master with fault detection off.
// [RULE_15] Control bit 6 switches the port off or on.
// [RULE_16] Control bit 4 picks slave role at 0 and master role at 1.
// [RULE_17] Control bit 3 sets the shift clock idle level.
// [RULE_18] Control bit 2 samples on the first edge at 0, the second at 1.
// [RULE_19] Reset clears every control bit.
// [RULE_20] Transfer-complete and write-collision flags are visible to software.
// [RULE_21] Two rate bits divide the clock by 2, 4, 8 or 16 in master role only.
// [RULE_22] With fault detection on, select is a fault input as master, select as slave.
// [RULE_23] Done flag set by hardware, cleared by software; blocks data writes while set.
// [RULE_24] Slave drives MISO only while its select input is low.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps

module spms_port (
  input wire logic clk_in,                        // System clock, 125 MHz
  input wire logic rst_in,                        // Synchronous reset, active high
  input wire spms_pkg::spms_avs_req_t bus_req_in, // Avalon-MM request
  output spms_pkg::spms_avs_rsp_t bus_rsp_out,    // Avalon-MM read data and waitrequest
  input wire spms_pkg::spms_pins_t pins_in,       // Levels seen on the four serial pins
  output spms_pkg::spms_pins_t pins_out,          // Levels driven on the serial pins
  output spms_pkg::spms_pins_t pins_oe_out        // Drive enables, high while driving
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // System clocks per shift clock half period, minus one
  function automatic logic [3:0] spms_half_ticks(input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      2'b00: r = 4'h0;
      2'b01: r = 4'h1;
      2'b10: r = 4'h3;
      default: r = 4'h7;
    endcase
    return r;
  endfunction : spms_half_ticks

  // Bit that leaves the shifter next
  function automatic logic spms_top(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction : spms_top

  // Shift one bit in at the end opposite to the leaving bit
  function automatic logic [7:0] spms_shift_in(input logic [7:0] v, input logic b,
                                               input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : spms_shift_in

  // ****************************************************************
  // State
  // ****************************************************************
  spms_pkg::spms_state_t s_q;
  spms_pkg::spms_state_t s_d;

  always_comb begin
    logic access;
    logic ack;
    logic wr_ok;
    logic [9:0] idx;
    logic [7:0] wb;
    logic en;
    logic master;
    logic lsb;
    logic edge_now;
    logic in_bit;
    logic [7:0] nxt_shift;
    logic [31:0] rdata;

    s_d = s_q;
    access = bus_req_in.read | bus_req_in.write;
    ack = access & ~s_q.rsp.waitrequest;
    idx = bus_req_in.address[11:2];
    wb = bus_req_in.writedata[7:0];
    wr_ok = ack & bus_req_in.write & bus_req_in.byteenable[0];
    en = s_q.ctrl[spms_pkg::SPMS_C_ON];
    master = s_q.ctrl[spms_pkg::SPMS_C_CTRL];
    lsb = s_q.ctrl[spms_pkg::SPMS_C_LSB];
    edge_now = 1'b0;
    in_bit = 1'b0;
    nxt_shift = s_q.shift;
    rdata = 32'h0000_0000;

    // ****************************************************************
    // Register slave
    // ****************************************************************
    // One wait cycle, then one cycle with waitrequest low; read data built in the wait cycle
    s_d.rsp.waitrequest = ~(access & s_q.rsp.waitrequest);
    case (idx)
      spms_pkg::SPMS_CTRL_IDX: rdata = {24'h000000, s_q.ctrl};
      spms_pkg::SPMS_STAT_IDX: rdata = {24'h000000, s_q.done, s_q.clash, s_q.ovf, s_q.fault,
                                        s_q.fault_off, s_q.tx_full, 2'b00}; // [RULE_20]
      spms_pkg::SPMS_DATA_IDX: rdata = {24'h000000, s_q.rx_buf}; // [RULE_03]
      default: rdata = 32'h0000_0000;
    endcase
    s_d.rsp.readdata = (access & s_q.rsp.waitrequest & bus_req_in.read) ? rdata : 32'h0;

    if (wr_ok) begin
      case (idx)
        spms_pkg::SPMS_CTRL_IDX: begin
          s_d.ctrl = wb;
        end
        spms_pkg::SPMS_STAT_IDX: begin
          // Flags clear when written as zero; hardware sets below take priority
          if (!wb[spms_pkg::SPMS_S_DONE]) s_d.done = 1'b0; // [RULE_23]
          if (!wb[spms_pkg::SPMS_S_CLASH]) s_d.clash = 1'b0;
          if (!wb[spms_pkg::SPMS_S_OVF]) s_d.ovf = 1'b0;
          if (!wb[spms_pkg::SPMS_S_FAULT]) s_d.fault = 1'b0;
          s_d.fault_off = wb[spms_pkg::SPMS_S_FOFF];
        end
        spms_pkg::SPMS_DATA_IDX: begin
          if (s_q.done) begin
            s_d.tx_full = s_q.tx_full; // [RULE_23]
          end else if (s_q.tx_full) begin
            s_d.clash = 1'b1; // [RULE_20]
          end else begin
            s_d.tx_buf = wb; // [RULE_02]
            s_d.tx_full = 1'b1;
          end
        end
        default: begin
          s_d.ctrl = s_q.ctrl;
        end
      endcase
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    case (s_q.mode)
      spms_pkg::SPMS_IDLE: begin
        s_d.sck_lvl = s_q.ctrl[spms_pkg::SPMS_C_IDLE]; // [RULE_17]
        s_d.edge_idx = 4'h0;
        s_d.div_cnt = 4'h0;
        if (en && master) begin // [RULE_15] [RULE_16]
          if (!s_q.fault_off && !pins_in.ss) begin
            // Another master owns the bus: drop to slave role and report
            s_d.fault = 1'b1; // [RULE_11] [RULE_22]
            s_d.ctrl[spms_pkg::SPMS_C_CTRL] = 1'b0;
          end else if (s_q.tx_full) begin
            s_d.shift = s_q.tx_buf; // [RULE_02]
            s_d.tx_full = 1'b0;
            s_d.out_bit = spms_top(s_q.tx_buf, lsb);
            s_d.mode = spms_pkg::SPMS_MASTER;
          end
        end else if (en && !master && !pins_in.ss) begin // [RULE_22]
          if (s_q.tx_full) begin
            s_d.shift = s_q.tx_buf;
            s_d.tx_full = 1'b0;
            s_d.out_bit = spms_top(s_q.tx_buf, lsb);
          end else begin
            // Nothing queued: the last received byte goes back out
            s_d.out_bit = spms_top(s_q.shift, lsb); // [RULE_12]
          end
          s_d.mode = spms_pkg::SPMS_SLAVE;
        end
      end
      spms_pkg::SPMS_MASTER: begin
        if (!en || !master) begin
          s_d.mode = spms_pkg::SPMS_IDLE; // [RULE_15]
        end else if (!s_q.fault_off && !pins_in.ss) begin
          s_d.fault = 1'b1; // [RULE_11]
          s_d.ctrl[spms_pkg::SPMS_C_CTRL] = 1'b0;
          s_d.mode = spms_pkg::SPMS_IDLE;
        end else if (s_q.div_cnt == spms_half_ticks(s_q.ctrl[1:0])) begin // [RULE_21]
          // Fastest setting toggles every clock: shift clock at half the system clock
          s_d.div_cnt = 4'h0; // [RULE_01]
          s_d.sck_lvl = ~s_q.sck_lvl;
          edge_now = 1'b1;
          in_bit = pins_in.miso; // [RULE_05]
        end else begin
          s_d.div_cnt = s_q.div_cnt + 4'h1;
        end
      end
      spms_pkg::SPMS_SLAVE: begin
        if (!en || master || pins_in.ss) begin
          // A partial byte is abandoned when select rises
          s_d.mode = spms_pkg::SPMS_IDLE; // [RULE_08]
        end else if (pins_in.sck != s_q.sck_prev) begin // [RULE_06]
          edge_now = 1'b1;
          in_bit = pins_in.mosi; // [RULE_04]
        end
      end
      default: begin
        s_d.mode = spms_pkg::SPMS_IDLE;
      end
    endcase
    s_d.sck_prev = pins_in.sck;

    // Sample edges take the input bit, the other edges present the next output bit
    if (edge_now) begin
      if (s_q.edge_idx[0] == s_q.ctrl[spms_pkg::SPMS_C_EDGE]) begin // [RULE_18]
        nxt_shift = spms_shift_in(s_q.shift, in_bit, lsb); // [RULE_12] [RULE_13]
        s_d.shift = nxt_shift;
      end else begin
        s_d.out_bit = spms_top(s_q.shift, lsb); // [RULE_13]
      end
      s_d.edge_idx = s_q.edge_idx + 4'h1;
      if (s_q.edge_idx == spms_pkg::SPMS_LAST_EDGE) begin // [RULE_07]
        s_d.rx_buf = nxt_shift; // [RULE_03]
        if (s_d.done) s_d.ovf = 1'b1;
        s_d.done = 1'b1; // [RULE_23]
        s_d.edge_idx = 4'h0;
        if (s_q.mode == spms_pkg::SPMS_MASTER) begin
          s_d.mode = spms_pkg::SPMS_IDLE;
        end else if (s_q.tx_full) begin
          s_d.shift = s_q.tx_buf;
          s_d.tx_full = 1'b0;
          s_d.out_bit = spms_top(s_q.tx_buf, lsb);
        end else begin
          s_d.out_bit = spms_top(nxt_shift, lsb);
        end
      end
    end

    // ****************************************************************
    // Pin drive, registered from next state
    // ****************************************************************
    s_d.pins_o.sck = (s_d.mode == spms_pkg::SPMS_MASTER) ? s_d.sck_lvl :
                     s_d.ctrl[spms_pkg::SPMS_C_IDLE]; // [RULE_17]
    s_d.pins_oe.sck = s_d.ctrl[spms_pkg::SPMS_C_ON] &
                      s_d.ctrl[spms_pkg::SPMS_C_CTRL]; // [RULE_06]
    s_d.pins_o.mosi = s_d.out_bit;
    s_d.pins_oe.mosi = s_d.ctrl[spms_pkg::SPMS_C_ON] &
                       s_d.ctrl[spms_pkg::SPMS_C_CTRL]; // [RULE_04]
    s_d.pins_o.miso = s_d.out_bit;
    s_d.pins_oe.miso = s_d.ctrl[spms_pkg::SPMS_C_ON] & ~s_d.ctrl[spms_pkg::SPMS_C_CTRL] &
                       (s_d.mode == spms_pkg::SPMS_SLAVE); // [RULE_24] [RULE_05]
    // Select low for the whole byte in master role
    s_d.pins_o.ss = (s_d.mode != spms_pkg::SPMS_MASTER); // [RULE_08] [RULE_14]
    s_d.pins_oe.ss = s_d.ctrl[spms_pkg::SPMS_C_ON] & s_d.ctrl[spms_pkg::SPMS_C_CTRL] &
                     s_d.fault_off & s_d.ctrl[spms_pkg::SPMS_C_SEL_OUT]; // [RULE_14]
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0; // [RULE_19]
      s_q.rsp.waitrequest <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rsp_out = s_q.rsp;
  assign pins_out = s_q.pins_o;
  assign pins_oe_out = s_q.pins_oe;

endmodule : spms_port

// ==== src/spms_pkg.sv ====
// Package for the serial master/slave port: register map, field layout, carriers and state.
package spms_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int SPMS_ADDR_W = 12;
  localparam int SPMS_DATA_W = 32;
  localparam int SPMS_IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [9:0] SPMS_CTRL_IDX = 10'h0f3;
  localparam logic [9:0] SPMS_STAT_IDX = 10'h0f4;
  localparam logic [9:0] SPMS_DATA_IDX = 10'h0f5;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int SPMS_C_SEL_OUT = 7;
  localparam int SPMS_C_ON = 6;
  localparam int SPMS_C_LSB = 5;
  localparam int SPMS_C_CTRL = 4;
  localparam int SPMS_C_IDLE = 3;
  localparam int SPMS_C_EDGE = 2;
  localparam int SPMS_C_RATE_HI = 1;
  localparam int SPMS_C_RATE_LO = 0;
  localparam logic [7:0] SPMS_CTRL_RST = 8'h00;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int SPMS_S_DONE = 7;
  localparam int SPMS_S_CLASH = 6;
  localparam int SPMS_S_OVF = 5;
  localparam int SPMS_S_FAULT = 4;
  localparam int SPMS_S_FOFF = 3;
  localparam int SPMS_S_TXFULL = 2;
  localparam logic [7:0] SPMS_STAT_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Shift clock toggles per byte: eight full periods
  localparam logic [3:0] SPMS_LAST_EDGE = 4'hf;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } spms_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } spms_avs_rsp_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spms_pins_t;

  typedef enum logic [1:0] {SPMS_IDLE, SPMS_MASTER, SPMS_SLAVE} spms_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic fault_off;
    logic done;
    logic clash;
    logic ovf;
    logic fault;
    logic tx_full;
    logic [7:0] tx_buf;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    spms_mode_t mode;
    logic [3:0] edge_idx;
    logic [3:0] div_cnt;
    logic sck_lvl;
    logic out_bit;
    logic sck_prev;
    spms_avs_rsp_t rsp;
    spms_pins_t pins_o;
    spms_pins_t pins_oe;
  } spms_state_t;

endpackage : spms_pkg

// ==== tb/spms_peer.sv ====
// Behavioural far-side slave on the serial link, shifting MSB first.
`timescale 1ns/1ps
module spms_peer (
  input wire logic sck_in,        // Shift clock from the master
  input wire logic mosi_in,       // Data from the master
  input wire logic ss_in,         // Select, low while addressed
  input wire logic clk_idle_level_in,       // Idle level of the shift clock
  input wire logic clk_sample_edge_in,       // High: sample on the second edge
  input wire logic [7:0] tx_in,   // Byte loaded at select fall
  output logic miso_out,          // Data to the master
  output logic [7:0] rx_out       // Byte received in the last frame
);
  logic [7:0] sr;
  logic b;
  logic act = 1'b0;
  initial miso_out = 1'b1;
  always @(negedge ss_in) begin
    act = 1'b1;
    sr = tx_in;
    miso_out = tx_in[7];
  end
  // Select rises in the time step of the last clock edge; the short hold lets that edge
  // shift first whatever order the two pin updates arrive in
  // Deselected: latch result, show a changed level since the line floats
  always @(posedge ss_in) begin
    #1;
    rx_out = sr;
    act = 1'b0;
    miso_out = ~miso_out;
  end
  // Two shifters form one ring, so the frame swaps the bytes
  always @(sck_in) if (act) begin
    if ((sck_in != clk_idle_level_in) ^ clk_sample_edge_in) begin
      if (clk_sample_edge_in) sr = {sr[6:0], mosi_in};
      else b = mosi_in;
    end else begin
      if (!clk_sample_edge_in) sr = {sr[6:0], b};
      miso_out = sr[7];
    end
  end
endmodule : spms_peer

// ==== tb/spms_port_chk.sv ====
// Concurrent checks on the serial port pins and its register bus.
`timescale 1ns/1ps
module spms_port_chk (
  input wire logic clk_in,                         // System clock
  input wire logic rst_in,                         // Synchronous reset
  input wire spms_pkg::spms_avs_req_t bus_req_in,  // Bus request
  input wire spms_pkg::spms_avs_rsp_t bus_rsp_out, // Bus response
  input wire spms_pkg::spms_pins_t pins_in,        // Pin levels
  input wire spms_pkg::spms_pins_t pins_out,       // Driven levels
  input wire spms_pkg::spms_pins_t pins_oe_out     // Drive enables
);
  // ****************************************
  // Shift clock toggles inside one select window
  // ****************************************
  logic [4:0] tog_q;
  logic sck_q;
  always_ff @(posedge clk_in) begin
    sck_q <= pins_out.sck;
    if (rst_in || pins_out.ss) tog_q <= 5'h0;
    else if (pins_out.sck != sck_q) tog_q <= tog_q + 5'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  oe_pair_a: assert property (pins_oe_out.sck == pins_oe_out.mosi)
    else $error("sck and mosi enables differ");
  miso_role_a: assert property (pins_oe_out.miso |-> !pins_oe_out.sck)
    else $error("miso driven in master role");
  miso_sel_a: assert property (pins_oe_out.miso |-> !$past(pins_in.ss))
    else $error("miso driven while deselected");
  ss_master_a: assert property (pins_oe_out.ss |-> pins_oe_out.sck)
    else $error("select driven outside master role");
  sel_hold_a: assert property ($fell(pins_out.ss) && pins_oe_out.ss && $past(pins_oe_out.ss)
    |=> (!pins_out.ss) [*8])
    else $error("select released early");
  // Counts the toggle landing on the release edge as well
  sck_count_a: assert property ($rose(pins_out.ss) && pins_oe_out.ss && $past(pins_oe_out.ss)
    |-> tog_q + 5'($changed(pins_out.sck)) == 5'd16)
    else $error("shift clock toggle count not 16");
  bus_ack_a: assert property ((bus_req_in.read || bus_req_in.write) && bus_rsp_out.waitrequest
    |=> !bus_rsp_out.waitrequest)
    else $error("bus request not answered");
  ack_once_a: assert property (!bus_rsp_out.waitrequest |=> bus_rsp_out.waitrequest)
    else $error("acknowledge longer than one cycle");
  rd_quiet_a: assert property (bus_rsp_out.waitrequest |-> bus_rsp_out.readdata == 32'h0)
    else $error("read data outside acknowledge");
endmodule : spms_port_chk

// ==== tb/spms_port_bench.sv ====
// Self-checking bench for the serial port with a slave model on the link.
`timescale 1ns/1ps
module spms_port_bench;
  localparam logic [11:0] CT = {spms_pkg::SPMS_CTRL_IDX, 2'b00};
  localparam logic [11:0] ST = {spms_pkg::SPMS_STAT_IDX, 2'b00};
  localparam logic [11:0] DT = {spms_pkg::SPMS_DATA_IDX, 2'b00};
  typedef struct {logic [7:0] c, d, p;} spms_row_t;
  spms_row_t rows[5] = '{'{8'hd0, 8'ha5, 8'h3c}, '{8'hd9, 8'h81, 8'h7e},
    '{8'hd6, 8'h5a, 8'hc3}, '{8'hff, 8'h01, 8'h80}, '{8'hf4, 8'h6d, 8'h12}};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  spms_pkg::spms_avs_req_t rq = '0;
  spms_pkg::spms_avs_rsp_t rs;
  spms_pkg::spms_pins_t po, oe, pi;
  logic bsck = 1'b0, bmosi = 1'b0, bss = 1'b1, pmiso, pc = 1'b0, ph = 1'b0, slv = 1'b0;
  logic [7:0] ptx = 8'h0, prx, r, got;
  logic [7:0] mtx = 8'h96;
  int errors = 0;
  int n_compared = 0;
  // Each pin resolves to whoever enables its driver; the bench stands in otherwise
  assign pi.sck = oe.sck ? po.sck : bsck;
  assign pi.mosi = oe.mosi ? po.mosi : bmosi;
  assign pi.ss = oe.ss ? po.ss : bss;
  assign pi.miso = oe.miso ? po.miso : pmiso;
  spms_port DUT (.clk_in(clk_in), .rst_in(rst_in), .bus_req_in(rq), .bus_rsp_out(rs),
    .pins_in(pi), .pins_out(po), .pins_oe_out(oe));
  spms_peer u_peer (.sck_in(pi.sck), .mosi_in(pi.mosi), .ss_in(pi.ss | slv), .clk_idle_level_in(pc),
    .clk_sample_edge_in(ph), .tx_in(ptx), .miso_out(pmiso), .rx_out(prx));
  initial forever #4 clk_in = ~clk_in;
  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    rq.read <= !w;
    rq.write <= w;
    rq.address <= a;
    rq.writedata <= {24'h0, d};
    rq.byteenable <= 4'h1;
    do @(posedge clk_in); while (rs.waitrequest !== 1'b0);
    r = rs.readdata[7:0];
    rq.read <= 1'b0;
    rq.write <= 1'b0;
  endtask : bus
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
    int t;
    t = 0;
    do begin
      bus(1'b0, ST, 8'h0);
      t++;
    end while ((r & m) !== v && t < 200);
  endtask : wait_stat
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    end_of_test();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, CT, 8'h0);
    chk("ctrl reset", 8'h00, r);
    bus(1'b0, 12'h000, 8'h0);
    chk("unmapped", 8'h00, r);
    bus(1'b1, ST, 8'h08);
    foreach (rows[i]) begin
      pc <= rows[i].c[3];
      ph <= rows[i].c[2];
      ptx <= rows[i].p;
      bus(1'b1, CT, rows[i].c);
      bus(1'b1, DT, rows[i].d);
      wait_stat(8'h80, 8'h80);
      bus(1'b0, DT, 8'h0);
      chk("rx byte", rows[i].c[5] ? {<<{rows[i].p}} : rows[i].p, r);
      chk("peer rx", rows[i].c[5] ? {<<{rows[i].d}} : rows[i].d, prx);
      bus(1'b1, ST, 8'h08);
    end
    $display("mode table done");
    pc <= 1'b0;
    ph <= 1'b0;
    ptx <= 8'h55;
    bus(1'b1, CT, 8'hd3);
    bus(1'b1, DT, 8'h11);
    bus(1'b1, DT, 8'h22);
    bus(1'b1, DT, 8'h33);
    bus(1'b0, ST, 8'h0);
    chk("queue full", 8'h44, r & 8'h44);
    wait_stat(8'h24, 8'h20);
    chk("peer second", 8'h22, prx);
    bus(1'b0, DT, 8'h0);
    chk("rx second", 8'h55, r);
    bus(1'b1, DT, 8'h44);
    bus(1'b0, ST, 8'h0);
    chk("status", 8'he8, r);
    $display("buffer test done");
    bus(1'b1, ST, 8'h00);
    bus(1'b1, CT, 8'h50);
    bss <= 1'b0;
    wait_stat(8'h10, 8'h10);
    chk("fault", 8'h10, r & 8'h10);
    bus(1'b0, CT, 8'h0);
    chk("role drop", 8'h40, r);
    bss <= 1'b1;
    $display("fault test done");
    slv <= 1'b1;
    bus(1'b1, ST, 8'h00);
    bus(1'b1, CT, 8'h40);
    bus(1'b1, DT, 8'h3c);
    bss <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bmosi <= mtx[i];
      repeat (4) @(posedge clk_in);
      bsck <= 1'b1;
      got[i] = pi.miso;
      repeat (4) @(posedge clk_in);
      bsck <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    bss <= 1'b1;
    chk("slave tx", 8'h3c, got);
    bus(1'b0, DT, 8'h0);
    chk("slave rx", 8'h96, r);
    bus(1'b0, ST, 8'h0);
    chk("slave status", 8'h80, r);
    bus(1'b1, CT, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("off enables", 8'h00, {4'h0, oe});
    $display("slave test done");
    end_of_test();
  end
endmodule : spms_port_bench
bind spms_port spms_port_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .bus_req_in(bus_req_in),
  .bus_rsp_out(bus_rsp_out), .pins_in(pins_in), .pins_out(pins_out), .pins_oe_out(pins_oe_out));
